// ==== logic/fws_defs.vh ====
// Constants for the flash status poller: status bit positions, bus timing, commands.
// Assumes a x8 or x16 flash data bus whose low byte carries the status bits.
`ifndef FWS_DEFS_VH
`define FWS_DEFS_VH

// Status bit positions on the data bus
`define FWS_BIT_POLL     7
`define FWS_BIT_TOG1     6
`define FWS_BIT_TIMEOUT  5
`define FWS_BIT_TOG2     2

// Read and write cycle timing in ns, converted to cycles at the system clock period
`define FWS_CLK_NS       8
`define FWS_T_ACC_NS     90
`define FWS_T_ACC_CYC    ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_HIGH_NS    16
`define FWS_T_HIGH_CYC   ((`FWS_T_HIGH_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_T_WP_NS      35
`define FWS_T_WP_CYC     ((`FWS_T_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

// Reset command data, written to any address
`define FWS_CMD_RESET    16'h00F0

// Poll method select
`define FWS_MODE_DATA    1'b0
`define FWS_MODE_TOGGLE  1'b1

// Result codes
`define FWS_RES_DONE     2'h0
`define FWS_RES_FAIL     2'h1
`define FWS_RES_PAUSED   2'h2

`endif

// ==== logic/fws_bus_cycle.v ====
// Single flash bus cycle engine: one read or one write on the asynchronous bus.
// Assumes the flash data pins are bidirectional and resolved outside this module.
`include "fws_defs.vh"

module fws_bus_cycle #(
	parameter AW = 22,
	parameter DW = 16
) (
	input  wire          i_sys_clk,
	input  wire          i_rst_n,
	input  wire          i_start,
	input  wire          i_write,
	input  wire [AW-1:0] i_addr,
	input  wire [DW-1:0] i_wdata,
	output wire          o_busy,
	output reg           o_done,
	output reg  [DW-1:0] o_rdata,
	output reg  [AW-1:0] o_fl_addr,
	output reg           o_fl_ce_n,
	output reg           o_fl_oe_n,
	output reg           o_fl_we_n,
	output reg  [DW-1:0] o_fl_dq,
	output reg           o_fl_dq_oe,
	input  wire [DW-1:0] i_fl_dq
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ACT  = 2'h1;
	localparam [1:0] ST_HIGH = 2'h2;
	// Counts are worked out as integers, then cut to the counter width on purpose
	localparam integer ACC_INT = `FWS_T_ACC_CYC;
	localparam integer WP_INT  = `FWS_T_WP_CYC;
	localparam integer HI_INT  = `FWS_T_HIGH_CYC;
	localparam [7:0]   ACC_CYC = ACC_INT[7:0];
	localparam [7:0]   WP_CYC  = WP_INT[7:0];
	localparam [7:0]   HI_CYC  = HI_INT[7:0];

	reg [1:0] st_q;
	reg [7:0] cnt_q;
	reg       wr_q;

	assign o_busy = (st_q != ST_IDLE);

	// Every read drops chip select and output enable anew, so each counts as a
	// separate read cycle for the toggle bits; a minimum high time follows.
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 8'h00;
			wr_q       <= 1'b0;
			o_done     <= 1'b0;
			o_rdata    <= {DW{1'b0}};
			o_fl_addr  <= {AW{1'b0}};
			o_fl_ce_n  <= 1'b1;
			o_fl_oe_n  <= 1'b1;
			o_fl_we_n  <= 1'b1;
			o_fl_dq    <= {DW{1'b0}};
			o_fl_dq_oe <= 1'b0;
		end else begin
			o_done <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (i_start) begin
						st_q       <= ST_ACT;
						wr_q       <= i_write;
						o_fl_addr  <= i_addr;
						o_fl_ce_n  <= 1'b0;
						o_fl_oe_n  <= i_write;
						o_fl_we_n  <= ~i_write;
						o_fl_dq    <= i_wdata;
						o_fl_dq_oe <= i_write;
						cnt_q      <= i_write ? WP_CYC : ACC_CYC;
					end
				end
				ST_ACT: begin
					if (cnt_q == 8'h01) begin
						// Data sampled at the end of access time, before release
						if (!wr_q)
							o_rdata <= i_fl_dq;
						o_fl_ce_n <= 1'b1;
						o_fl_oe_n <= 1'b1;
						o_fl_we_n <= 1'b1;
						cnt_q     <= HI_CYC;
						st_q      <= ST_HIGH;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_HIGH: begin
					if (cnt_q == 8'h01) begin
						o_fl_dq_oe <= 1'b0;
						o_done     <= 1'b1;
						st_q       <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // fws_bus_cycle

// ==== logic/fws_poller.v ====
// Host side status poller for a parallel NOR flash program or erase operation.
// Assumes the flash is already given its command; the poller waits and reports.
// Function
// - Host polls the poll bit at the address being programmed.
// - Host reads erase status inside a selected, unprotected sector.
// - Poll bit may settle before low bits; take data from a later read.
// - After timeout flag seen, re-read poll bit before declaring failure.
// - Toggle poll starts with two reads; no change means finished.
// - Toggling with timeout high: test again; still toggling means fail, reset.
// - Returning from other work restarts toggle polling with a double read.
`include "fws_defs.vh"

module fws_poller #(
	parameter AW = 22,
	parameter DW = 16
) (
	input  wire          i_sys_clk,
	input  wire          i_resetn,
	input  wire          i_start,
	input  wire          i_mode,
	input  wire [AW-1:0] i_addr,
	input  wire [DW-1:0] i_exp_data,
	input  wire          i_pause,
	output wire          o_ready,
	output reg           o_done,
	output reg  [1:0]    o_result,
	output reg  [DW-1:0] o_final_data,
	output reg           o_suspended,
	output reg           o_erasing_here,
	output wire          o_dev_busy,
	output wire [AW-1:0] o_fl_addr,
	output wire          o_fl_ce_n,
	output wire          o_fl_oe_n,
	output wire          o_fl_we_n,
	output wire [DW-1:0] o_fl_dq,
	output wire          o_fl_dq_oe,
	input  wire [DW-1:0] i_fl_dq,
	input  wire          i_fl_ready_busy_n
);
	localparam [3:0] ST_IDLE    = 4'h0;
	localparam [3:0] ST_RD1     = 4'h1;
	localparam [3:0] ST_W1      = 4'h2;
	localparam [3:0] ST_RD2     = 4'h3;
	localparam [3:0] ST_W2      = 4'h4;
	localparam [3:0] ST_EVAL    = 4'h5;
	localparam [3:0] ST_RECHK   = 4'h6;
	localparam [3:0] ST_WR      = 4'h7;
	localparam [3:0] ST_FINAL   = 4'h8;
	localparam [3:0] ST_REPORT  = 4'h9;
	localparam [3:0] ST_RST     = 4'hA;
	localparam [3:0] ST_W3      = 4'hB;

	// Reset release through two flops
	reg rst_s1_q;
	reg rst_n_q;
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	reg  [3:0]    st_q;
	reg           mode_q;
	reg  [AW-1:0] addr_q;
	reg  [DW-1:0] exp_q;
	reg  [DW-1:0] first_q;
	reg           chk_q;
	reg  [1:0]    res_q;
	reg           cyc_start;
	reg           cyc_write;
	wire          cyc_busy;
	wire          cyc_done;
	wire [DW-1:0] cyc_rdata;

	fws_bus_cycle #(
		.AW(AW),
		.DW(DW)
	) u_cycle (
		.i_sys_clk  (i_sys_clk),
		.i_rst_n    (rst_n_q),
		.i_start    (cyc_start),
		.i_write    (cyc_write),
		.i_addr     (addr_q),
		.i_wdata    (`FWS_CMD_RESET),
		.o_busy     (cyc_busy),
		.o_done     (cyc_done),
		.o_rdata    (cyc_rdata),
		.o_fl_addr  (o_fl_addr),
		.o_fl_ce_n  (o_fl_ce_n),
		.o_fl_oe_n  (o_fl_oe_n),
		.o_fl_we_n  (o_fl_we_n),
		.o_fl_dq    (o_fl_dq),
		.o_fl_dq_oe (o_fl_dq_oe),
		.i_fl_dq    (i_fl_dq)
	);

	// Ready/busy is an open-drain input, inverted straight through with no sampling flop
	assign o_dev_busy = ~i_fl_ready_busy_n;
	assign o_ready    = (st_q == ST_IDLE);

	// Status decode from the latest read against first read or expected data
	wire poll_ok  = (cyc_rdata[`FWS_BIT_POLL] == exp_q[`FWS_BIT_POLL]);
	wire tog1_chg = (cyc_rdata[`FWS_BIT_TOG1] != first_q[`FWS_BIT_TOG1]);
	wire tog2_chg = (cyc_rdata[`FWS_BIT_TOG2] != first_q[`FWS_BIT_TOG2]);
	wire tmo      = cyc_rdata[`FWS_BIT_TIMEOUT];

	// Handshake into the cycle engine
	always @* begin
		cyc_start = 1'b0;
		cyc_write = 1'b0;
		case (st_q)
			ST_RD1, ST_RD2, ST_FINAL: cyc_start = ~cyc_busy;
			ST_WR: begin
				cyc_start = ~cyc_busy;
				cyc_write = 1'b1;
			end
			default: cyc_start = 1'b0;
		endcase
	end

	// Polling sequence; the poll address is always the user's target address,
	// which must be the program address or inside a selected sector
	always @(posedge i_sys_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q           <= ST_IDLE;
			mode_q         <= `FWS_MODE_DATA;
			addr_q         <= {AW{1'b0}};
			exp_q          <= {DW{1'b0}};
			first_q        <= {DW{1'b0}};
			chk_q          <= 1'b0;
			res_q          <= `FWS_RES_DONE;
			o_done         <= 1'b0;
			o_result       <= `FWS_RES_DONE;
			o_final_data   <= {DW{1'b0}};
			o_suspended    <= 1'b0;
			o_erasing_here <= 1'b0;
		end else begin
			o_done <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					// Start only after the command's last write strobe is done
					if (i_start) begin
						mode_q <= i_mode;
						addr_q <= i_addr;
						exp_q  <= i_exp_data;
						chk_q  <= 1'b0;
						st_q   <= ST_RD1;
					end
				end
				ST_RD1: if (cyc_start) st_q <= ST_W1;
				ST_W1: begin
					if (cyc_done) begin
						first_q <= cyc_rdata;
						// Data polling needs one read; toggle polling needs two
						st_q <= (mode_q == `FWS_MODE_DATA) ? ST_EVAL : ST_RD2;
					end
				end
				ST_RD2: if (cyc_start) st_q <= ST_W2;
				ST_W2: if (cyc_done) st_q <= ST_EVAL;
				ST_EVAL: begin
					if (mode_q == `FWS_MODE_DATA) begin
						if (poll_ok) begin
							res_q <= `FWS_RES_DONE;
							st_q  <= ST_FINAL;
						end else if (chk_q) begin
							res_q <= `FWS_RES_FAIL;
							st_q  <= ST_WR;
						end else if (tmo) begin
							chk_q <= 1'b1;
							st_q  <= ST_RD1;
						end else begin
							st_q <= ST_RECHK;
						end
					end else begin
						o_erasing_here <= tog2_chg;
						o_suspended    <= ~tog1_chg & tog2_chg;
						if (!tog1_chg) begin
							res_q <= `FWS_RES_DONE;
							st_q  <= ST_FINAL;
						end else if (chk_q) begin
							res_q <= `FWS_RES_FAIL;
							st_q  <= ST_WR;
						end else if (tmo) begin
							chk_q <= 1'b1;
							first_q <= cyc_rdata;
							st_q  <= ST_RD2;
						end else begin
							st_q <= ST_RECHK;
						end
					end
				end
				ST_RECHK: begin
					// A pause ends the poll with a paused result; a new start in toggle mode begins again with two reads
					if (i_pause) begin
						res_q <= `FWS_RES_PAUSED;
						st_q  <= ST_REPORT;
					end else begin
						st_q <= ST_RD1;
					end
				end
				ST_WR: if (cyc_start) st_q <= ST_RST;
				ST_RST: if (cyc_done) st_q <= ST_REPORT;
				ST_FINAL: if (cyc_start) st_q <= ST_W3;
				ST_W3: begin
					// Fresh read after completion so all data bits are settled
					if (cyc_done) begin
						o_final_data <= cyc_rdata;
						st_q         <= ST_REPORT;
					end
				end
				ST_REPORT: begin
					o_done   <= 1'b1;
					o_result <= res_q;
					st_q     <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	// Protected-sector cases (short program, long erase activity) and partial
	// protection need no special path: polling simply ends when activity stops.
endmodule // fws_poller

// ==== verif/fws_poller_props.sv ====
// Port checker for the flash status poller.
// Assumes the poller top ports; bound in below, single clock domain.
module fws_poller_props #(
	parameter AW = 22,
	parameter DW = 16
) (
	input wire logic          i_sys_clk,
	input wire logic          i_resetn,
	input wire logic          i_start,
	input wire logic [AW-1:0] i_addr,
	input wire logic          o_ready,
	input wire logic          o_done,
	input wire logic          o_dev_busy,
	input wire logic          i_fl_ready_busy_n,
	input wire logic [AW-1:0] o_fl_addr,
	input wire logic          o_fl_ce_n,
	input wire logic          o_fl_oe_n,
	input wire logic          o_fl_we_n,
	input wire logic [DW-1:0] o_fl_dq,
	input wire logic          o_fl_dq_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	// Reads last the full access time, so status is never sampled early
	AST_READ_LEN: assert property ($fell(o_fl_oe_n) |-> ##11 !o_fl_oe_n ##1 o_fl_oe_n)
		else $error("read strobe length wrong");
	// A gap between reads makes each one a distinct read cycle
	AST_READ_GAP: assert property ($rose(o_fl_oe_n) |-> o_fl_oe_n [*2])
		else $error("read strobes too close");
	AST_SELECTED: assert property (!o_fl_oe_n |-> !o_fl_ce_n && o_fl_we_n)
		else $error("read without select");
	AST_ADDR_HOLD: assert property (!o_fl_ce_n && $past(!o_fl_ce_n) |-> $stable(o_fl_addr))
		else $error("address moved in a cycle");
	// The only write ever issued is the reset command
	AST_WRITE_RESET: assert property (!o_fl_we_n |-> o_fl_dq == 16'h00F0 && o_fl_dq_oe)
		else $error("write is not reset command");
	AST_WRITE_LEN: assert property ($fell(o_fl_we_n) |-> ##4 !o_fl_we_n ##1 o_fl_we_n)
		else $error("write strobe length wrong");
	AST_BUSY_PIN: assert property (o_dev_busy == !i_fl_ready_busy_n)
		else $error("busy flag not tracking pin");
	AST_DONE_PULSE: assert property (o_done |=> !o_done)
		else $error("done longer than one cycle");
	AST_START_TAKEN: assert property (i_start && o_ready |=> !o_ready)
		else $error("start not taken");
	// Status is only valid at the target address, so every cycle uses it
	AST_ADDR_TARGET: assert property (!o_fl_ce_n |-> o_fl_addr == i_addr)
		else $error("bus cycle not at poll address");
	// The device drives the whole bus during a read; never fight it
	AST_NO_FIGHT: assert property (!o_fl_oe_n |-> !o_fl_dq_oe)
		else $error("data driven during read");
endmodule // fws_poller_props

bind fws_poller fws_poller_props #(.AW(AW), .DW(DW)) u_props (.i_sys_clk(i_sys_clk),
	.i_resetn(i_resetn), .i_start(i_start), .i_addr(i_addr), .o_ready(o_ready), .o_done(o_done),
	.o_dev_busy(o_dev_busy), .i_fl_ready_busy_n(i_fl_ready_busy_n), .o_fl_addr(o_fl_addr),
	.o_fl_ce_n(o_fl_ce_n), .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n),
	.o_fl_dq(o_fl_dq), .o_fl_dq_oe(o_fl_dq_oe));

// ==== verif/fws_flash_model.sv ====
// Behavioural flash status model: program, erase or suspended, counted in reads.
// Assumes the bench starts each operation with a one-cycle i_go pulse.
module fws_flash_model (
	input wire logic        i_clk,
	input wire logic        i_go,
	input wire logic [1:0]  i_op,
	input wire logic [7:0]  i_n,
	input wire logic        i_tmo,
	input wire logic [15:0] i_dat,
	input wire logic        i_ce_n,
	input wire logic        i_oe_n,
	input wire logic        i_we_n,
	input wire logic [15:0] i_dq,
	output logic [15:0]     o_dq,
	output logic            o_rb_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] left_q;
	logic [1:0] op_q;
	logic t1_q, t2_q, to_q, rd_q;
	logic [15:0] word_q, last_q, s;
	wire rd = !i_ce_n && !i_oe_n;
	wire act = left_q != 8'h00 || op_q == 2'h2;
	// Status word; low bits are junk while busy
	assign s = {8'h5A, (op_q == 2'h0) ? ~word_q[7] : op_q[1], t1_q, to_q, 2'b00, t2_q, 2'b00};
	// Undriven bus shows the inverse of the last word, never a stale match
	assign o_dq = rd ? (act ? s : word_q) : ~last_q;
	assign o_rb_n = left_q == 8'h00; // Pulled up when idle or suspended
	// Status valid from start; protected cases are just short counts
	always @(posedge i_clk) begin
		rd_q <= rd;
		if (rd)
			last_q <= o_dq;
		if (i_go) begin
			{left_q, op_q, to_q, word_q, t1_q, t2_q} <= {i_n, i_op, i_tmo, i_dat, 2'b00};
		end else if (!i_we_n && i_dq == 16'h00F0) begin
			{left_q, op_q, to_q} <= 11'h000;
		end else if (rd_q && !rd && act) begin
			if (left_q != 8'h00) begin
				left_q <= left_q - 8'h01;
				t1_q <= ~t1_q; // Toggle one only while busy
			end
			if (op_q != 2'h0)
				t2_q <= ~t2_q; // Toggle two in erase sectors
		end
	end
endmodule // fws_flash_model

// ==== verif/fws_poller_test.sv ====
// Testbench for the flash status poller against the behavioural flash model.
// Assumes the poller reads status and writes only the reset command.
module fws_poller_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_sys_clk = 0, i_resetn = 0, i_start = 0, i_mode = 0, i_pause = 0, go = 0, tmo = 0;
	logic [21:0] i_addr = 22'h000100;
	logic [15:0] i_exp_data = 16'h0000, dat = 16'h0000, md_dq;
	logic [1:0] op = 2'h0;
	logic [7:0] n = 8'h00;
	wire o_ready, o_done, o_suspended, o_erasing_here, o_dev_busy, ce_n, oe_n, we_n, dq_oe, rb_n;
	wire [1:0] o_result;
	wire [15:0] o_final_data, o_fl_dq;
	wire [15:0] fl_dq = dq_oe ? o_fl_dq : md_dq;
	int n_errors = 0, check_count = 0, cyc = 0, w;
	// Case table: mode, operation, busy reads, timeout, pause, result
	int tm[10] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1};
	int tp[10] = '{0, 0, 1, 2, 0, 0, 1, 2, 0, 0};
	int tn[10] = '{3, 1, 3, 0, 255, 3, 4, 0, 255, 255};
	int tt[10] = '{0, 0, 0, 0, 1, 0, 0, 0, 1, 0};
	int tz[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1};
	int tr[10] = '{0, 0, 0, 0, 1, 0, 0, 0, 1, 2};

	fws_poller dut_u (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_start(i_start),
		.i_mode(i_mode), .i_addr(i_addr), .i_exp_data(i_exp_data), .i_pause(i_pause),
		.o_ready(o_ready), .o_done(o_done), .o_result(o_result), .o_final_data(o_final_data),
		.o_suspended(o_suspended), .o_erasing_here(o_erasing_here), .o_dev_busy(o_dev_busy),
		.o_fl_addr(), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n), .o_fl_we_n(we_n), .o_fl_dq(o_fl_dq),
		.o_fl_dq_oe(dq_oe), .i_fl_dq(fl_dq), .i_fl_ready_busy_n(rb_n));
	fws_flash_model flash_u (.i_clk(i_sys_clk), .i_go(go), .i_op(op), .i_n(n), .i_tmo(tmo),
		.i_dat(dat), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(fl_dq), .o_dq(md_dq),
		.o_rb_n(rb_n));

	always #4 i_sys_clk = ~i_sys_clk;
	// Hang guard, far above the longest case
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			conclude();
		end
	end

	task chk(string nm, logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	task conclude();
		$display("checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One job: start the flash operation, then the poller, then judge the outcome
	task run(int k);
		@(posedge i_sys_clk);
		go <= 1;
		op <= tp[k][1:0];
		n <= tn[k][7:0];
		tmo <= tt[k][0];
		dat <= tp[k] != 0 ? 16'hFFFF : (k[0] ? 16'h00C3 : 16'h1234);
		i_addr <= 22'h000100 + k[21:0];
		@(posedge i_sys_clk);
		go <= 0;
		i_mode <= tm[k][0];
		i_exp_data <= dat;
		i_pause <= tz[k][0];
		i_start <= 1;
		@(posedge i_sys_clk);
		i_start <= 0;
		#1 chk("dev_busy_start", o_dev_busy, tn[k] != 0);
		w = 0;
		do begin
			@(posedge i_sys_clk);
			#1 w++;
		end while (o_done !== 1'b1 && w < 20000);
		chk("done_seen", o_done, 1'b1);
		chk("result", o_result, tr[k][1:0]);
		if (tm[k] == 1) begin
			chk("suspended", o_suspended, tp[k] == 2);
			chk("erasing_here", o_erasing_here, tp[k] == 2);
		end
		if (tr[k] == 0 && tp[k] != 2)
			chk("final_data", o_final_data, dat);
		if (tz[k] == 0)
			chk("dev_busy_end", o_dev_busy, 1'b0);
	endtask

	initial begin
		repeat (3) @(posedge i_sys_clk);
		i_resetn <= 1;
		repeat (3) @(posedge i_sys_clk);
		for (int k = 0; k < 10; k++)
			run(k);
		conclude();
	end
endmodule // fws_poller_test
